/* uart_dev_model.sv */
// device model: register file, transmit shifter and receive buffer of the serial unit.
// assumes one-cycle host register strobes; the bench injects received frames and breaks.
`timescale 1ns/1ps
`default_nettype none

module uart_dev_model
    import uart_host_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire devReq_t devReq,
    output logic [7:0] devRdata,
    output logic devTxDone,
    output logic devRxDone,
    // bench side
    input wire logic linMode,
    input wire logic rxGo,
    input wire logic rxBreak,
    input wire logic [7:0] rxByte,
    input wire logic [7:0] rxErr
);
    logic [7:0] mode, baud, clkSel, ext, rxErrReg, rxBuf, latch, txByte, rdVal;
    logic full, busy, rxFull, errRead, brkTx, brkRx;
    logic [8:0] cnt;
    int violations, txCount;
    wire logic [7:0] d = devReq.wdata;
    wire logic enOn = mode[MODE_TXEN] | mode[MODE_RXEN];

    always_comb
        case (devReq.addr)
            DEV_MODE: rdVal = mode;
            DEV_TXSTAT: rdVal = {6'h00, full, busy};
            DEV_BAUD: rdVal = baud;
            DEV_CLKSEL: rdVal = clkSel;
            DEV_EXTCTL: rdVal = ext & 8'h9f;
            DEV_RXERR: rdVal = rxErrReg;
            DEV_RXBUF: rdVal = rxBuf;
            default: rdVal = 8'h00;
        endcase

    always @(posedge clock)
    begin
        devTxDone <= 1'b0;
        devRxDone <= 1'b0;
        // unread cycles invert the last value, so the stale answer returns every second cycle
        devRdata <= devReq.read ? rdVal : ~devRdata;
        if (!rst_n)
        begin
            {mode, baud, clkSel, ext, rxErrReg, rxBuf, latch, txByte} <= '0;
            {full, busy, rxFull, errRead, brkTx, brkRx, cnt} <= '0;
            violations <= 0;
            txCount <= 0;
        end
        else
        begin
            if (full && !busy && !brkTx && cnt == 9'h000)
            begin
                busy <= 1'b1;
                full <= 1'b0;
                cnt <= {baud, 1'b0};
            end
            else if (cnt != 9'h000)
                cnt <= cnt - 9'h001;
            else if (busy || brkTx)
            begin
                {busy, brkTx} <= 2'b00;
                ext[EXT_BRK_TX] <= 1'b0;
                devTxDone <= 1'b1;
            end
            if (rxGo && rxBreak && brkRx)
            begin
                brkRx <= 1'b0;
                ext[EXT_BRK_RX] <= 1'b0;
                devRxDone <= 1'b1;
            end
            else if (rxGo && !rxBreak && mode[MODE_RXEN])
            begin
                if (rxFull)
                    rxErrReg <= rxErrReg | 8'h01;
                else
                begin
                    {rxBuf, rxErrReg, rxFull} <= {rxByte, rxErr, 1'b1};
                    devRxDone <= 1'b1;
                end
            end
            if (devReq.read && devReq.addr == DEV_RXERR)
                errRead <= 1'b1;
            if (devReq.read && devReq.addr == DEV_RXBUF)
            begin
                violations <= violations + int'(!errRead);
                {errRead, rxFull, rxErrReg} <= '0;
            end
            if (devReq.write)
                case (devReq.addr)
                    DEV_MODE:
                    begin
                        violations <= violations + int'((|d[6:5] && !mode[7]) || (!d[7] && |mode[6:5])
                            || (linMode && |d[4:3]) || (mode[6] && !d[6] && (full || busy)));
                        mode <= d;
                    end
                    DEV_CLKSEL:
                    begin
                        violations <= violations + int'(mode[MODE_POWER]);
                        clkSel <= d;
                    end
                    DEV_BAUD:
                    begin
                        violations <= violations + int'(enOn);
                        baud <= d;
                    end
                    DEV_EXTCTL:
                    begin
                        violations <= violations + int'((enOn && d[1:0] != ext[1:0])
                            || (d[6] && !(mode[7] && mode[5])) || (d[5] && !(mode[7] && mode[6])));
                        // a refresh with both triggers at 0 leaves a running break alone
                        ext <= d;
                        brkRx <= brkRx | d[EXT_BRK_RX];
                        brkTx <= brkTx | d[EXT_BRK_TX];
                        if (d[EXT_BRK_TX])
                            cnt <= {baud, 1'b0};
                    end
                    DEV_TXBUF:
                    begin
                        violations <= violations + int'(full || (linMode && busy));
                        full <= 1'b1;
                        txByte <= d;
                        txCount <= txCount + 1;
                    end
                    DEV_PORTLATCH: latch <= d;
                    DEV_PORTDIR: violations <= violations + int'(!d[3] && !latch[3]);
                    default: ;
                endcase
        end
    end
endmodule

`default_nettype wire

/* uart_host_pkg.sv */
// uart host package: device register map, own register map, carriers and states.
// assumes the device answers a read on the cycle after its read strobe.
`default_nettype none

package uart_host_pkg;

    // ******************************************************
    // device register indices, reached through the device port
    // ******************************************************
    localparam logic [3:0] DEV_MODE = 4'h0;
    localparam logic [3:0] DEV_TXSTAT = 4'h1;
    localparam logic [3:0] DEV_BAUD = 4'h2;
    localparam logic [3:0] DEV_CLKSEL = 4'h3;
    localparam logic [3:0] DEV_EXTCTL = 4'h4;
    localparam logic [3:0] DEV_RXERR = 4'h5;
    localparam logic [3:0] DEV_TXBUF = 4'h6;
    localparam logic [3:0] DEV_RXBUF = 4'h7;
    localparam logic [3:0] DEV_PORTLATCH = 4'h8;
    localparam logic [3:0] DEV_PORTDIR = 4'h9;

    // ******************************************************
    // device field positions and values
    // ******************************************************
    localparam int MODE_POWER = 7;
    localparam int MODE_TXEN = 6;
    localparam int MODE_RXEN = 5;
    localparam int MODE_PAR_LSB = 3;
    localparam int TXSTAT_FULL = 1;
    localparam int TXSTAT_BUSY = 0;
    localparam int EXT_BRK_RX = 6;
    localparam int EXT_BRK_TX = 5;
    localparam int EXT_DIR = 1;
    localparam int EXT_INV = 0;
    localparam logic [7:0] PORT_LATCH_HIGH = 8'h08;
    localparam logic [7:0] PORT_DIR_OUT = 8'hf7;
    localparam logic [7:0] TXSTAT_IDLE = 8'h00;

    // ******************************************************
    // own registers on the ahb-lite side
    // ******************************************************
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_COMMAND = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RXDATA = 8'h10;
    localparam logic [16:0] CONFIG_RESET = 17'h00010;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_BRK_TX = 2;
    localparam int CMD_BRK_RX = 3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ******************************************************
    // carriers and states
    // ******************************************************
    typedef struct packed {
        logic [1:0] parity;
        logic lin;
        logic inv;
        logic dir;
        logic [3:0] prescale;
        logic [7:0] divisor;
    } cfg_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [3:0] addr;
        logic [7:0] wdata;
    } devReq_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h00,
        ST_LATCH = 5'h01,
        ST_DIR = 5'h03,
        ST_CLK = 5'h02,
        ST_BAUD = 5'h06,
        ST_EXT = 5'h07,
        ST_PWR = 5'h05,
        ST_EN = 5'h04,
        ST_TXPOLL = 5'h0c,
        ST_TXCHK = 5'h0d,
        ST_TXWR = 5'h0f,
        ST_RXERR = 5'h0e,
        ST_RXERRCAP = 5'h0a,
        ST_RXBUF = 5'h0b,
        ST_RXBUFCAP = 5'h09,
        ST_STPOLL = 5'h18,
        ST_STCHK = 5'h19,
        ST_STDIS = 5'h1b,
        ST_STOFF = 5'h1a,
        ST_BRK = 5'h12,
        ST_BRKWAIT = 5'h13
    } state_t;

endpackage

`default_nettype wire

/* uart_lin_host.sv */
// uart host: sequences the serial unit's registers on behalf of software.
// assumes one device whose register port answers reads one cycle after the strobe
// and whose completion interrupts arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module uart_lin_host
    import uart_host_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // device register port
    output devReq_t devReq,
    input wire logic [7:0] devRdata,
    // device completion pulses
    input wire logic devTxDone,
    input wire logic devRxDone
);

    // ******************************************************
    // ahb-lite slave
    // ******************************************************
    state_t state;
    state_t nextState;
    cfg_t cfg;
    cfg_t cfgRun;
    logic running;
    logic startPend;
    logic stopPend;
    logic brkPend;
    logic brkIsRx;
    logic brkDone;
    logic txPend;
    logic [7:0] txByte;
    logic rxEvent;
    logic rxValid;
    logic [7:0] rxByte;
    logic [7:0] rxErr;
    logic wrPhase;
    logic [7:0] wrAddr;

    wire addrTaken = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
    wire rdTaken = addrTaken && !hwrite;
    wire wrData = wrPhase;
    wire cmdWrite = wrData && wrAddr == REG_COMMAND;
    wire busy = state != ST_IDLE;
    wire [31:0] statusWord = {26'h0, rxErr != 8'h00, brkDone, rxValid, txPend, busy, running};
    wire [31:0] readWord =
        haddr[7:0] == REG_CONFIG ? {15'h0, cfg} :
        haddr[7:0] == REG_STATUS ? statusWord :
        haddr[7:0] == REG_RXDATA ? {16'h0, rxErr, rxByte} : 32'h0;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h0;
            wrPhase <= 1'b0;
            wrAddr <= 8'h00;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= rdTaken ? readWord : 32'h0;
            wrPhase <= addrTaken && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // ******************************************************
    // software orders
    // ******************************************************
    // orders that cannot apply now are dropped, not queued
    wire startOk = cmdWrite && hwdata[CMD_START] && !running && !startPend;
    wire stopOk = cmdWrite && hwdata[CMD_STOP] && running && !stopPend;
    // breaks only while running, which lasts until the stop sequence ends, and re-armed as soon as ST_BRK is left, even mid-break
    wire brkOk = cmdWrite && (hwdata[CMD_BRK_TX] || hwdata[CMD_BRK_RX]) && running && !brkPend;
    wire txOk = wrData && wrAddr == REG_TXDATA && running && !txPend;
    wire rxRead = rdTaken && haddr[7:0] == REG_RXDATA;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cfg <= cfg_t'(CONFIG_RESET);
            startPend <= 1'b0;
            stopPend <= 1'b0;
            brkPend <= 1'b0;
            brkIsRx <= 1'b0;
            txPend <= 1'b0;
            txByte <= 8'h00;
        end
        else
        begin
            if (wrData && wrAddr == REG_CONFIG)
                cfg <= cfg_t'(hwdata[16:0]);
            startPend <= startOk || (startPend && state != ST_LATCH);
            stopPend <= stopOk || (stopPend && state != ST_STPOLL);
            brkPend <= brkOk || (brkPend && state != ST_BRK);
            if (brkOk)
                brkIsRx <= hwdata[CMD_BRK_RX];
            txPend <= txOk || (txPend && state != ST_TXWR);
            if (txOk)
                txByte <= hwdata[7:0];
        end
    end

    // ******************************************************
    // sequencer
    // ******************************************************
    // in lin mode the whole status must be idle, else only buffer-full counts
    wire txRoom = cfgRun.lin ? devRdata == TXSTAT_IDLE : !devRdata[TXSTAT_FULL];
    wire shiftIdle = !devRdata[TXSTAT_BUSY] && !devRdata[TXSTAT_FULL];
    wire brkEnd = brkIsRx ? devRxDone : devTxDone;

    always_comb
    begin
        nextState = state;
        unique case (state)
            ST_IDLE:
            begin
                if (stopPend)
                    nextState = ST_STPOLL;
                else if (startPend)
                    nextState = ST_LATCH;
                else if (rxEvent && running)
                    nextState = ST_RXERR;
                else if (brkPend)
                    nextState = ST_BRK;
                else if (txPend)
                    nextState = ST_TXPOLL;
            end
            ST_LATCH: nextState = ST_DIR;
            ST_DIR: nextState = ST_CLK;
            ST_CLK: nextState = ST_BAUD;
            ST_BAUD: nextState = ST_EXT;
            ST_EXT: nextState = ST_PWR;
            ST_PWR: nextState = ST_EN;
            ST_EN: nextState = ST_IDLE;
            ST_TXPOLL: nextState = ST_TXCHK;
            ST_TXCHK: nextState = txRoom ? ST_TXWR : ST_TXPOLL;
            ST_TXWR: nextState = ST_IDLE;
            ST_RXERR: nextState = ST_RXERRCAP;
            ST_RXERRCAP: nextState = ST_RXBUF;
            ST_RXBUF: nextState = ST_RXBUFCAP;
            ST_RXBUFCAP: nextState = ST_IDLE;
            ST_STPOLL: nextState = ST_STCHK;
            ST_STCHK: nextState = shiftIdle ? ST_STDIS : ST_STPOLL;
            ST_STDIS: nextState = ST_STOFF;
            ST_STOFF: nextState = ST_IDLE;
            ST_BRK: nextState = ST_BRKWAIT;
            // trigger left alone until the next completion pulse of the direction brkIsRx selects
            ST_BRKWAIT: nextState = brkEnd ? ST_IDLE : ST_BRKWAIT;
            default: nextState = ST_IDLE;
        endcase
    end

    // ******************************************************
    // device accesses, decoded from the coming state
    // ******************************************************
    // lin frames carry no parity
    wire [1:0] parity = cfgRun.lin ? 2'b00 : cfgRun.parity;
    wire [7:0] modeOn = 8'h80 | {3'b000, parity, 3'b000};
    wire [7:0] modeRun = modeOn | 8'h60;
    // triggers written as 0 keep every ordinary rewrite harmless
    wire [7:0] extBase = {6'h00, cfgRun.dir, cfgRun.inv};
    wire [7:0] extBrk = extBase | (brkIsRx ? 8'h40 : 8'h20);
    devReq_t next_devReq;

    always_comb
    begin
        next_devReq = '0;
        unique case (nextState)
            ST_LATCH: next_devReq = '{1'b1, 1'b0, DEV_PORTLATCH, PORT_LATCH_HIGH};
            ST_DIR: next_devReq = '{1'b1, 1'b0, DEV_PORTDIR, PORT_DIR_OUT};
            ST_CLK: next_devReq = '{1'b1, 1'b0, DEV_CLKSEL, {4'h0, cfgRun.prescale}};
            // divisor is software's pick; it must suit the far receiver
            ST_BAUD: next_devReq = '{1'b1, 1'b0, DEV_BAUD, cfgRun.divisor};
            ST_EXT: next_devReq = '{1'b1, 1'b0, DEV_EXTCTL, extBase};
            ST_PWR: next_devReq = '{1'b1, 1'b0, DEV_MODE, modeOn};
            ST_EN: next_devReq = '{1'b1, 1'b0, DEV_MODE, modeRun};
            ST_TXPOLL: next_devReq = '{1'b0, 1'b1, DEV_TXSTAT, 8'h00};
            ST_TXWR: next_devReq = '{1'b1, 1'b0, DEV_TXBUF, txByte};
            ST_RXERR: next_devReq = '{1'b0, 1'b1, DEV_RXERR, 8'h00};
            ST_RXBUF: next_devReq = '{1'b0, 1'b1, DEV_RXBUF, 8'h00};
            ST_STPOLL: next_devReq = '{1'b0, 1'b1, DEV_TXSTAT, 8'h00};
            ST_STDIS: next_devReq = '{1'b1, 1'b0, DEV_MODE, modeOn};
            ST_STOFF: next_devReq = '{1'b1, 1'b0, DEV_MODE, 8'h00};
            ST_BRK: next_devReq = '{1'b1, 1'b0, DEV_EXTCTL, extBrk};
            default: next_devReq = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            devReq <= '0;
            cfgRun <= cfg_t'(CONFIG_RESET);
            running <= 1'b0;
        end
        else
        begin
            state <= nextState;
            devReq <= next_devReq;
            // snapshot so later config writes never reach a live unit
            if (nextState == ST_LATCH)
                cfgRun <= cfg;
            running <= (running || state == ST_EN) && state != ST_STOFF;
        end
    end

    // ******************************************************
    // receive capture and break status
    // ******************************************************
    // every reception is followed by an error read then a buffer read
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rxEvent <= 1'b0;
            rxValid <= 1'b0;
            rxByte <= 8'h00;
            rxErr <= 8'h00;
            brkDone <= 1'b0;
        end
        else
        begin
            rxEvent <= devRxDone || (rxEvent && state != ST_RXERR);
            rxValid <= state == ST_RXBUFCAP || (rxValid && !rxRead);
            if (state == ST_RXERRCAP)
                rxErr <= devRdata;
            if (state == ST_RXBUFCAP)
                rxByte <= devRdata;
            // a failed break leaves the device flag set; software orders another
            brkDone <= (state == ST_BRKWAIT && brkEnd) || (brkDone && !brkOk);
        end
    end

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic [7:0] modeShadow;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            modeShadow <= 8'h00;
        else if (devReq.write && devReq.addr == DEV_MODE)
            modeShadow <= devReq.wdata;
    end

    wire modeWr = devReq.write && devReq.addr == DEV_MODE;
    wire extWr = devReq.write && devReq.addr == DEV_EXTCTL;

    sequence s_setup;
        state == ST_DIR ##1 state == ST_CLK ##1 state == ST_BAUD ##1 state == ST_EXT;
    endsequence
    sequence s_powerUp;
        state == ST_PWR ##1 state == ST_EN ##1 running;
    endsequence

    a_start_order: assert property (state == ST_LATCH |=> s_setup ##1 s_powerUp)
        else $error("start sequence out of order");
    a_tx_full_gate: assert property (state == ST_TXWR |-> $past(state) == ST_TXCHK
        && !$past(devRdata[TXSTAT_FULL]))
        else $error("byte written while buffer full");
    a_lin_status_idle: assert property (state == ST_TXWR && cfgRun.lin |-> $past(devRdata) == TXSTAT_IDLE)
        else $error("lin byte written with status not idle");
    a_stop_shift_idle: assert property (state == ST_STDIS |-> $past(state) == ST_STCHK
        && !$past(devRdata[TXSTAT_BUSY]))
        else $error("transmitter shut while shifting");
    a_clock_sel_off: assert property (devReq.write && devReq.addr == DEV_CLKSEL |-> !modeShadow[MODE_POWER])
        else $error("prescaler rewritten with power on");
    a_baud_enables_off: assert property (devReq.write && devReq.addr == DEV_BAUD
        |-> !modeShadow[MODE_TXEN] && !modeShadow[MODE_RXEN])
        else $error("divisor rewritten with enables on");
    a_order_bits_off: assert property (extWr && !devReq.wdata[EXT_BRK_TX] && !devReq.wdata[EXT_BRK_RX]
        |-> !modeShadow[MODE_TXEN] && !modeShadow[MODE_RXEN])
        else $error("bit order changed with enables on");
    a_brk_tx_power: assert property (extWr && devReq.wdata[EXT_BRK_TX]
        |-> modeShadow[MODE_POWER] && modeShadow[MODE_TXEN])
        else $error("break transmit armed while off");
    a_brk_rx_power: assert property (extWr && devReq.wdata[EXT_BRK_RX]
        |-> modeShadow[MODE_POWER] && modeShadow[MODE_RXEN])
        else $error("break receive armed while off");
    a_power_sequence: assert property (modeWr && devReq.wdata[MODE_TXEN] |-> modeShadow[MODE_POWER]
        ##0 $past(modeWr, 1))
        else $error("enables set before power");
    a_stop_power_last: assert property (modeWr && !devReq.wdata[MODE_POWER]
        |-> !modeShadow[MODE_TXEN] && !modeShadow[MODE_RXEN])
        else $error("power cleared before enables");
    a_latch_first: assert property (devReq.write && devReq.addr == DEV_PORTDIR
        |-> $past(devReq.write) && $past(devReq.addr) == DEV_PORTLATCH)
        else $error("pin made output before latch high");
    a_lin_no_parity: assert property (modeWr && cfgRun.lin |-> devReq.wdata[4:3] == 2'b00)
        else $error("parity set in lin mode");
    a_err_before_buf: assert property (devReq.read && devReq.addr == DEV_RXBUF
        |-> $past(devReq.read, 2) && $past(devReq.addr, 2) == DEV_RXERR)
        else $error("buffer read before error status");
    a_rx_always_read: assert property (state == ST_RXERR |-> ##3 state == ST_RXBUFCAP)
        else $error("receive buffer read skipped");
    a_ctrl_triggers: assert property (state == ST_EXT |-> devReq.wdata[EXT_BRK_RX:EXT_BRK_TX] == 2'b00)
        else $error("trigger set on plain control write");

endmodule

`default_nettype wire

/* uart_lin_host_tb_top.sv */
// bench for the serial host: drives the ahb-lite side, judges the device model's view.
// assumes the device model compiles before this file.
`timescale 1ns/1ps
`default_nettype none

module uart_lin_host_tb_top
    import uart_host_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] wd; logic [31:0] exp;} row_t;
    logic clock, rst_n, hsel, hwrite, rxGo, rxBreak, linMode, hreadyout, hresp, devTxDone, devRxDone;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] rxByte, rxErr, devRdata;
    wire logic hready = hreadyout;
    devReq_t devReq;
    int numErrors = 0, nTests = 0, cycles = 0, i;
    row_t rows [8] = '{'{1'b0, REG_CONFIG, 32'h0, {15'h0000, CONFIG_RESET}},
        '{1'b1, REG_CONFIG, 32'hffffffff, 32'h0}, '{1'b0, REG_CONFIG, 32'h0, 32'h0001ffff},
        '{1'b1, 8'h14, 32'hffffffff, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h0}, '{1'b0, REG_STATUS, 32'h0, 32'h0},
        '{1'b1, REG_CONFIG, 32'h3903, 32'h0}, '{1'b0, REG_CONFIG, 32'h0, 32'h3903}};

    uart_lin_host dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .devReq(devReq), .devRdata(devRdata), .devTxDone(devTxDone),
        .devRxDone(devRxDone));
    uart_dev_model dev (.clock(clock), .rst_n(rst_n), .devReq(devReq), .devRdata(devRdata),
        .devTxDone(devTxDone), .devRxDone(devRxDone), .linMode(linMode), .rxGo(rxGo),
        .rxBreak(rxBreak), .rxByte(rxByte), .rxErr(rxErr));

    // ******
    // bus cycles and checks
    // ******
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge clock);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, wr};
        do @(posedge clock); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
        // every transfer must end with an okay response
        chk(32'(hresp), 32'h0);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            numErrors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // polls status until the masked bits match, bounded
    task automatic waitSt(input logic [31:0] mask, input logic [31:0] val);
        logic [31:0] r;
        for (int k = 0; k < 300; k++)
        begin
            ahb(1'b0, REG_STATUS, 32'h0, r);
            if ((r & mask) === val)
                break;
        end
        chk(r & mask, val);
    endtask

    task automatic waitTx(input int n);
        for (i = 0; i < 400 && dev.txCount != n; i++)
            @(posedge clock);
        chk(32'(dev.txCount), 32'(n));
    endtask

    task automatic rxIn(input logic [7:0] b, input logic [7:0] e, input logic brk);
        @(posedge clock);
        {rxGo, rxByte, rxErr, rxBreak} <= {1'b1, b, e, brk};
        @(posedge clock);
        rxGo <= 1'b0;
        rxByte <= ~b;
    endtask

    task automatic wrapUp();
        $display("comparisons %0d, errors %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // the whole run needs a few hundred cycles
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            numErrors++;
            wrapUp();
        end
    end

    // ******
    // main sequence
    // ******
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, rxGo, rxBreak, rxByte, rxErr, linMode} = '0;
        hsize = HSIZE_WORD;
        rst_n = 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int k = 0; k < 8; k++)
        begin
            ahb(rows[k].wr, rows[k].a, rows[k].wd, rd);
            if (!rows[k].wr)
                chk(rd, rows[k].exp);
        end
        ahb(1'b1, REG_COMMAND, 32'h1, rd);
        waitSt(32'h1, 32'h1);
        chk(32'(dev.baud), 32'h03);
        chk(32'(dev.clkSel), 32'h09);
        chk(32'(dev.ext), 32'h03);
        chk(32'(dev.mode), 32'he0);
        chk(32'(dev.latch[3]), 32'h1);
        // second byte passes the poll while the first shifts and lands a cycle after it ends; the third finds the buffer empty
        ahb(1'b1, REG_TXDATA, 32'ha5, rd);
        waitSt(32'h4, 32'h0);
        ahb(1'b1, REG_TXDATA, 32'h5a, rd);
        waitSt(32'h4, 32'h0);
        ahb(1'b1, REG_TXDATA, 32'h3c, rd);
        waitTx(3);
        chk(32'(dev.txByte), 32'h3c);
        rxIn(8'h96, 8'h00, 1'b0);
        waitSt(32'h8, 32'h8);
        ahb(1'b0, REG_RXDATA, 32'h0, rd);
        chk(rd, 32'h0096);
        rxIn(8'h41, 8'h04, 1'b0);
        waitSt(32'h28, 32'h28);
        ahb(1'b0, REG_RXDATA, 32'h0, rd);
        chk(rd, 32'h0441);
        // two frames back to back: the second overruns and is lost
        @(posedge clock);
        {rxGo, rxByte, rxErr, rxBreak} <= {1'b1, 8'h11, 8'h00, 1'b0};
        @(posedge clock);
        rxByte <= 8'h22;
        @(posedge clock);
        rxGo <= 1'b0;
        waitSt(32'h28, 32'h28);
        ahb(1'b0, REG_RXDATA, 32'h0, rd);
        chk(rd, 32'h0111);
        ahb(1'b1, REG_COMMAND, 32'h4, rd);
        waitSt(32'h10, 32'h10);
        chk(32'(dev.ext[EXT_BRK_TX]), 32'h0);
        ahb(1'b1, REG_COMMAND, 32'h8, rd);
        for (i = 0; i < 100 && dev.brkRx !== 1'b1; i++)
            @(posedge clock);
        rxIn(8'h00, 8'h00, 1'b1);
        waitSt(32'h10, 32'h10);
        chk(32'(dev.brkRx), 32'h0);
        // stop ordered while a byte is still shifting
        ahb(1'b1, REG_TXDATA, 32'h77, rd);
        waitSt(32'h4, 32'h0);
        ahb(1'b1, REG_COMMAND, 32'h2, rd);
        waitSt(32'h1, 32'h0);
        chk(32'(dev.mode), 32'h0);
        chk(32'(dev.busy), 32'h0);
        ahb(1'b1, REG_TXDATA, 32'h99, rd);
        ahb(1'b1, REG_CONFIG, 32'h0001c003, rd);
        linMode <= 1'b1;
        ahb(1'b1, REG_COMMAND, 32'h1, rd);
        waitSt(32'h1, 32'h1);
        chk(32'(dev.mode), 32'he0);
        ahb(1'b1, REG_TXDATA, 32'h55, rd);
        waitSt(32'h4, 32'h0);
        ahb(1'b1, REG_TXDATA, 32'haa, rd);
        waitTx(6);
        chk(32'(dev.violations), 32'h0);
        // mid-run reset with a byte still shifting; model counters restart too
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk(32'(hreadyout), 32'h0);
        chk(hrdata, 32'h0);
        chk(32'(devReq), 32'h0);
        rst_n <= 1'b1;
        ahb(1'b0, REG_CONFIG, 32'h0, rd);
        chk(rd, {15'h0000, CONFIG_RESET});
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd, 32'h0);
        wrapUp();
    end
endmodule

`default_nettype wire
